// ### core/rcfv_params.svh
// constants of the reset cause and fault vector block
`ifndef RCFV_PARAMS_SVH
`define RCFV_PARAMS_SVH
`define RCFV_OFS_VECTOR   12'h015E
`define RCFV_OFS_CTRL     12'h0160
`define RCFV_OFS_FLAGS    12'h0164
`define RCFV_OFS_PASSWORD 12'h0168
`define RCFV_ADDR_BITS    12
`define RCFV_CODE_NONE    8'h00
`define RCFV_CODE_BROWN   8'h02
`define RCFV_CODE_PIN     8'h04
`define RCFV_CODE_SWBOR   8'h06
`define RCFV_CODE_WAKE    8'h08
`define RCFV_CODE_SECUR   8'h0A
`define RCFV_CODE_SVSH    8'h0E
`define RCFV_CODE_SWPOR   8'h14
`define RCFV_CODE_WDT     8'h16
`define RCFV_CODE_WATCHDOG_PASSWORD   8'h18
`define RCFV_CODE_MEMPW   8'h1A
`define RCFV_CODE_UBE     8'h1C
`define RCFV_CODE_FETCH   8'h1E
`define RCFV_CODE_POWER_MGMT_PASSWORD   8'h20
`define RCFV_CODE_FLL     8'h24
`define RCFV_NUM_SRC      14
`define RCFV_PW_KEY       8'hA5
`define RCFV_BIT_NMI      0
`define RCFV_BIT_PROG_WP  1
`define RCFV_BIT_INFO_WP  2
`define RCFV_BIT_OSC_IE   3
`define RCFV_BIT_CBE      0
`define RCFV_BIT_UBE      1
`define RCFV_BIT_ACCV     2
`define RCFV_BIT_OSC      3
`define RCFV_CTRL_RESET   4'h0
`endif

// ### core/rcfv_pkg.sv
// types of the reset cause and fault vector block
package rcfv_pkg;
	typedef enum logic [1:0] {
		RCFV_IDLE = 2'b01,
		RCFV_DATA = 2'b10
	} rcfv_phase_t;
	typedef logic [13:0] rcfv_src_t;
endpackage : rcfv_pkg

// ### core/rcfv_top.sv
// reset cause vector, protection bits and fault flags behind an ahb-lite slave
`timescale 1ns/10ps
`include "rcfv_params.svh"
// Operation
// - after any reset software reads the cause vector at 015Eh
// - vector reads 00h when nothing pending; brownout 02h ranks highest
// - reset pin cause reports code 04h, brownout class
// - software brownout request reports code 06h
// - deep low power wake reports 08h; security violation reports 0Ah
// - high side supervisor event reports 0Eh; 0Ch 10h 12h never produced
// - software power-on request reports code 14h
// - watchdog timeout reports code 16h
// - wrong watchdog password reports code 18h
// - wrong memory controller password reports code 1Ah
// - uncorrectable memory bit error reports code 1Ch
// - fetch from peripheral area reports code 1Eh
// - wrong power management password reports 20h; 22h reserved
// - critical registers accept writes only with correct password
// - reset pin can become non-maskable interrupt input instead of reset
// - two bits block program and information memory writes
// - separate correctable and uncorrectable bit error flags
// - access violation flag set on memory access violation
// - oscillator fault flag set on crystal failure, optional interrupt
module rcfv_top (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        brownout_event,
	input  wire logic        reset_pin_event,
	input  wire logic        software_brownout_request,
	input  wire logic        deep_wake_event,
	input  wire logic        security_violation,
	input  wire logic        high_side_supervisor_flag,
	input  wire logic        software_poweron_request,
	input  wire logic        watchdog_timeout_flag,
	input  wire logic        watchdog_password_bad,
	input  wire logic        memctl_password_bad,
	input  wire logic        uncorrectable_error_event,
	input  wire logic        correctable_error_event,
	input  wire logic        peripheral_fetch,
	input  wire logic        power_mgmt_password_bad,
	input  wire logic        fll_unlock,
	input  wire logic        access_violation_event,
	input  wire logic        crystal_one_fault,
	input  wire logic        mem_write_req,
	input  wire logic        mem_write_info,
	output logic             mem_write_grant,
	output logic             nmi_pulse,
	output logic             pin_reset_req,
	output logic             brownout_class_reset,
	output logic             power_up_clear_reset,
	output logic             oscillator_fault_irq
);
	//////////////////////////////////////////////////////////////////////
	logic                 rd_ff;
	logic                 wr_ff;
	logic [11:0]          addr_ff;
	logic [3:0]           ctrl_ff;
	logic [3:0]           flags_ff;
	rcfv_pkg::rcfv_src_t  pend_ff;
	rcfv_pkg::rcfv_src_t  raw_src;
	rcfv_pkg::rcfv_src_t  top_onehot;
	logic [7:0]           top_code;
	logic                 addr_ok;
	logic                 vec_read;
	logic                 ctrl_write;
	logic                 pw_ok;
	// code per priority slot, index 0 highest
	function automatic logic [7:0] slot_code(input int idx);
		logic [7:0] c;
		c = `RCFV_CODE_NONE;
		unique case (idx)
			0:  c = `RCFV_CODE_BROWN;
			1:  c = `RCFV_CODE_PIN;
			2:  c = `RCFV_CODE_SWBOR;
			3:  c = `RCFV_CODE_WAKE;
			4:  c = `RCFV_CODE_SECUR;
			5:  c = `RCFV_CODE_SVSH;
			6:  c = `RCFV_CODE_SWPOR;
			7:  c = `RCFV_CODE_WDT;
			8:  c = `RCFV_CODE_WATCHDOG_PASSWORD;
			9:  c = `RCFV_CODE_MEMPW;
			10: c = `RCFV_CODE_UBE;
			11: c = `RCFV_CODE_FETCH;
			12: c = `RCFV_CODE_POWER_MGMT_PASSWORD;
			13: c = `RCFV_CODE_FLL;
			default: c = `RCFV_CODE_NONE;
		endcase
		return c;
	endfunction : slot_code
	//////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states, always okay
	assign addr_ok = hsel && hready && htrans[1];
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ff   <= 1'b0;
			wr_ff   <= 1'b0;
			addr_ff <= 12'h000;
		end else begin
			if (hready) begin
				rd_ff   <= addr_ok && !hwrite;
				wr_ff   <= addr_ok && hwrite;
				addr_ff <= haddr[`RCFV_ADDR_BITS-1:0];
			end
		end
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	// vector address is halfword-aligned; any address in its word reaches it
	assign vec_read   = addr_ok && !hwrite && (haddr[11:2] == `RCFV_OFS_VECTOR >> 2);
	assign ctrl_write = wr_ff && (addr_ff[11:2] == `RCFV_OFS_CTRL >> 2);
	assign pw_ok      = hwdata[15:8] == `RCFV_PW_KEY;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			unique case (haddr[11:2])
				`RCFV_OFS_VECTOR >> 2: hrdata <= {8'h00, top_code, 16'h0000} >> 16;
				`RCFV_OFS_CTRL >> 2:   hrdata <= {28'h000_0000, ctrl_ff};
				`RCFV_OFS_FLAGS >> 2:  hrdata <= {28'h000_0000, flags_ff};
				default:               hrdata <= 32'h0000_0000;
			endcase
		end
	end
	//////////////////////////////////////////////////////////////////////
	// pending causes; reserved codes have no slot
	assign raw_src = {fll_unlock, power_mgmt_password_bad, peripheral_fetch,
		uncorrectable_error_event, memctl_password_bad, watchdog_password_bad,
		watchdog_timeout_flag, software_poweron_request, high_side_supervisor_flag,
		security_violation, deep_wake_event, software_brownout_request,
		reset_pin_event && !ctrl_ff[`RCFV_BIT_NMI], brownout_event};
	assign top_onehot = pend_ff & (~pend_ff + 14'h0001);
	always_comb begin
		top_code = `RCFV_CODE_NONE;
		for (int i = `RCFV_NUM_SRC - 1; i >= 0; i--) begin
			if (pend_ff[i]) top_code = slot_code(i);
		end
	end
	// new events win over the read clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend_ff <= 14'h0001;
		end else begin
			pend_ff <= (pend_ff & ~(vec_read ? top_onehot : 14'h0000)) | raw_src;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// control: password in bits 15:8, bad key ignored and raises power_up_clear_reset elsewhere, no vector code
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= `RCFV_CTRL_RESET;
		end else if (ctrl_write && pw_ok) begin
			ctrl_ff <= hwdata[3:0];
		end
	end
	// flags: write one to clear, set wins
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flags_ff <= 4'h0;
		end else begin
			flags_ff <= (flags_ff & ~((wr_ff && addr_ff[11:2] == `RCFV_OFS_FLAGS >> 2) ? hwdata[3:0] : 4'h0))
				| {crystal_one_fault, access_violation_event, uncorrectable_error_event,
				correctable_error_event};
		end
	end
	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_write_grant      <= 1'b0;
			nmi_pulse            <= 1'b0;
			pin_reset_req        <= 1'b0;
			brownout_class_reset <= 1'b0;
			power_up_clear_reset <= 1'b0;
			oscillator_fault_irq <= 1'b0;
		end else begin
			mem_write_grant      <= mem_write_req && !(mem_write_info ? ctrl_ff[`RCFV_BIT_INFO_WP]
				: ctrl_ff[`RCFV_BIT_PROG_WP]);
			nmi_pulse            <= reset_pin_event && ctrl_ff[`RCFV_BIT_NMI];
			pin_reset_req        <= reset_pin_event && !ctrl_ff[`RCFV_BIT_NMI];
			brownout_class_reset <= |raw_src[5:0];
			power_up_clear_reset <= |raw_src[13:7] || (ctrl_write && !pw_ok);
			oscillator_fault_irq <= flags_ff[`RCFV_BIT_OSC] && ctrl_ff[`RCFV_BIT_OSC_IE];
		end
	end
	//////////////////////////////////////////////////////////////////////
	a_empty_reads_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		(vec_read && pend_ff == 14'h0000) |=> hrdata == 32'h0000_0000)
		else $error("vector not zero when empty");
	a_brown_top: assert property (@(posedge ref_clk) disable iff (!nrst)
		(vec_read && pend_ff[0]) |=> hrdata[7:0] == `RCFV_CODE_BROWN)
		else $error("brownout not highest");
	a_pin_code: assert property (@(posedge ref_clk) disable iff (!nrst)
		(vec_read && pend_ff[1:0] == 2'b10) |=> hrdata[7:0] == `RCFV_CODE_PIN)
		else $error("pin code wrong");
	a_read_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
		(vec_read && pend_ff[0] && !brownout_event) |=> !pend_ff[0])
		else $error("read did not clear");
	a_nmi_no_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
		(reset_pin_event && ctrl_ff[`RCFV_BIT_NMI]) |=> !pin_reset_req && nmi_pulse)
		else $error("pin reset while nmi");
	a_prog_protect: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mem_write_req && !mem_write_info && ctrl_ff[`RCFV_BIT_PROG_WP]) |=> !mem_write_grant)
		else $error("protected write granted");
	a_bad_pw_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ctrl_write && !pw_ok) |=> $stable(ctrl_ff) && power_up_clear_reset)
		else $error("bad password accepted");
	a_ube_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
		uncorrectable_error_event |=> flags_ff[`RCFV_BIT_UBE] && pend_ff[10])
		else $error("ube not flagged");
	a_wdt_pending: assert property (@(posedge ref_clk) disable iff (!nrst)
		watchdog_timeout_flag |=> pend_ff[7] ##0 power_up_clear_reset)
		else $error("watchdog not recorded");
	a_osc_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
		(flags_ff[`RCFV_BIT_OSC] && ctrl_ff[`RCFV_BIT_OSC_IE]) |=> oscillator_fault_irq)
		else $error("osc irq missing");
	// later checks share one clock and reset
	default clocking rcfv_cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// code of each slot when it is the top one
	a_swbor_code: assert property (
		(vec_read && pend_ff[2:0] == 3'h4) |=> hrdata[7:0] == `RCFV_CODE_SWBOR)
		else $error("swbor code wrong");
	a_wake_code: assert property (
		(vec_read && pend_ff[3:0] == 4'h8) |=> hrdata[7:0] == `RCFV_CODE_WAKE)
		else $error("wake code wrong");
	a_secur_code: assert property (
		(vec_read && pend_ff[4:0] == 5'h10) |=> hrdata[7:0] == `RCFV_CODE_SECUR)
		else $error("security code wrong");
	a_svsh_code: assert property (
		(vec_read && pend_ff[5:0] == 6'h20) |=> hrdata[7:0] == `RCFV_CODE_SVSH)
		else $error("supervisor code wrong");
	a_swpor_code: assert property (
		(vec_read && pend_ff[6:0] == 7'h40) |=> hrdata[7:0] == `RCFV_CODE_SWPOR)
		else $error("swpor code wrong");
	a_wdt_code: assert property (
		(vec_read && pend_ff[7:0] == 8'h80) |=> hrdata[7:0] == `RCFV_CODE_WDT)
		else $error("watchdog code wrong");
	a_watchdog_password_code: assert property (
		(vec_read && pend_ff[8:0] == 9'h100) |=> hrdata[7:0] == `RCFV_CODE_WATCHDOG_PASSWORD)
		else $error("watchdog key code wrong");
	a_mempw_code: assert property (
		(vec_read && pend_ff[9:0] == 10'h200) |=> hrdata[7:0] == `RCFV_CODE_MEMPW)
		else $error("memctl key code wrong");
	a_ube_code: assert property (
		(vec_read && pend_ff[10:0] == 11'h400) |=> hrdata[7:0] == `RCFV_CODE_UBE)
		else $error("bit error code wrong");
	a_fetch_code: assert property (
		(vec_read && pend_ff[11:0] == 12'h800) |=> hrdata[7:0] == `RCFV_CODE_FETCH)
		else $error("fetch code wrong");
	a_power_mgmt_password_code: assert property (
		(vec_read && pend_ff[12:0] == 13'h1000) |=> hrdata[7:0] == `RCFV_CODE_POWER_MGMT_PASSWORD)
		else $error("power key code wrong");
	a_fll_code: assert property (
		(vec_read && pend_ff == 14'h2000) |=> hrdata[7:0] == `RCFV_CODE_FLL)
		else $error("fll code wrong");
	// each source is recorded and drives its class; swpor drives no class
	a_brown_pend: assert property (
		brownout_event |=> pend_ff[0] && brownout_class_reset)
		else $error("brownout not recorded");
	a_pin_pend: assert property (
		(reset_pin_event && !ctrl_ff[`RCFV_BIT_NMI]) |=> pend_ff[1] && pin_reset_req)
		else $error("pin reset not recorded");
	a_swbor_pend: assert property (
		software_brownout_request |=> pend_ff[2] && brownout_class_reset)
		else $error("swbor not recorded");
	a_wake_pend: assert property (
		deep_wake_event |=> pend_ff[3] && brownout_class_reset)
		else $error("wake not recorded");
	a_secur_pend: assert property (
		security_violation |=> pend_ff[4] && brownout_class_reset)
		else $error("security not recorded");
	a_svsh_pend: assert property (
		high_side_supervisor_flag |=> pend_ff[5] && brownout_class_reset)
		else $error("supervisor not recorded");
	a_swpor_pend: assert property (
		software_poweron_request |=> pend_ff[6])
		else $error("swpor not recorded");
	a_watchdog_password_pend: assert property (
		watchdog_password_bad |=> pend_ff[8] && power_up_clear_reset)
		else $error("watchdog key not recorded");
	a_mempw_pend: assert property (
		memctl_password_bad |=> pend_ff[9] && power_up_clear_reset)
		else $error("memctl key not recorded");
	a_fetch_pend: assert property (
		peripheral_fetch |=> pend_ff[11] && power_up_clear_reset)
		else $error("fetch not recorded");
	a_power_mgmt_password_pend: assert property (
		power_mgmt_password_bad |=> pend_ff[12] && power_up_clear_reset)
		else $error("power key not recorded");
	a_fll_pend: assert property (
		fll_unlock |=> pend_ff[13] && power_up_clear_reset)
		else $error("fll not recorded");
	a_swpor_no_class: assert property (
		(software_poweron_request && raw_src == 14'h0040 && !ctrl_write)
		|=> !brownout_class_reset && !power_up_clear_reset) else $error("swpor drove a class");
	// vector and unmapped read behaviour
	a_reserved_codes: assert property (
		vec_read |=> hrdata[31:8] == 24'h00_0000 && !(hrdata[7:0] inside {8'h0C, 8'h10, 8'h12, 8'h22}))
		else $error("reserved code seen");
	a_one_pop: assert property (
		(vec_read && pend_ff != 14'h0000 && raw_src == 14'h0000)
		|=> $countones(pend_ff) == $countones($past(pend_ff)) - 1) else $error("read cleared not one");
	a_unmapped_zero: assert property (
		(addr_ok && !hwrite && haddr[11:2] > (`RCFV_OFS_PASSWORD >> 2)) |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	// read data only moves on a read
	a_hrdata_hold: assert property (
		!(addr_ok && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
	// protection, control and flags
	a_info_protect: assert property (
		(mem_write_req && mem_write_info && ctrl_ff[`RCFV_BIT_INFO_WP]) |=> !mem_write_grant)
		else $error("info write granted");
	a_grant_open: assert property (
		(mem_write_req && !mem_write_info && !ctrl_ff[`RCFV_BIT_PROG_WP]) |=> mem_write_grant)
		else $error("open write refused");
	a_grant_quiet: assert property (
		!mem_write_req |=> !mem_write_grant)
		else $error("grant without request");
	a_pw_load: assert property (
		(ctrl_write && pw_ok) |=> ctrl_ff == $past(hwdata[3:0]))
		else $error("good key not loaded");
	a_ctrl_read: assert property (
		(addr_ok && !hwrite && haddr[11:2] == (`RCFV_OFS_CTRL >> 2)) |=> hrdata == {28'h000_0000, $past(ctrl_ff)})
		else $error("control readback wrong");
	a_cbe_flag: assert property (
		correctable_error_event |=> flags_ff[`RCFV_BIT_CBE])
		else $error("cbe not flagged");
	a_accv_flag: assert property (
		access_violation_event |=> flags_ff[`RCFV_BIT_ACCV])
		else $error("access violation not flagged");
	a_osc_flag: assert property (
		crystal_one_fault |=> flags_ff[`RCFV_BIT_OSC])
		else $error("osc fault not flagged");
	a_flag_clear: assert property (
		(wr_ff && addr_ff[11:2] == (`RCFV_OFS_FLAGS >> 2) && hwdata[`RCFV_BIT_CBE] && !correctable_error_event)
		|=> !flags_ff[`RCFV_BIT_CBE]) else $error("flag not cleared");
	a_irq_off: assert property (
		!ctrl_ff[`RCFV_BIT_OSC_IE] |=> !oscillator_fault_irq)
		else $error("osc irq while disabled");
	a_nmi_quiet: assert property (
		!reset_pin_event |=> !nmi_pulse && !pin_reset_req)
		else $error("pin output without event");
	a_nmi_no_cause: assert property (
		(reset_pin_event && ctrl_ff[`RCFV_BIT_NMI] && !vec_read) |=> pend_ff[1] == $past(pend_ff[1]))
		else $error("nmi recorded as reset");
	c_vector_read: cover property (@(posedge ref_clk) disable iff (!nrst) vec_read && pend_ff != 14'h0000);
	c_walk_to_zero: cover property (@(posedge ref_clk) disable iff (!nrst)
		vec_read ##1 vec_read && pend_ff == 14'h0000);
	c_nmi_mode: cover property (@(posedge ref_clk) disable iff (!nrst) nmi_pulse);
	c_fault_irq: cover property (@(posedge ref_clk) disable iff (!nrst) oscillator_fault_irq);
	c_bad_key: cover property (@(posedge ref_clk) disable iff (!nrst) ctrl_write && !pw_ok);
endmodule : rcfv_top

// ### testbench/reset_cause_fault_vector_tb.sv
// self-checking bench of the reset cause and fault vector block
`timescale 1ns/10ps
`include "rcfv_params.svh"
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module reset_cause_fault_vector_tb;
	logic        ref_clk, nrst, hwrite, hreadyout, hresp, mem_write_req, mem_write_info, mem_write_grant;
	logic        nmi_pulse, pin_reset_req, brownout_class_reset, power_up_clear_reset, oscillator_fault_irq;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, r, m;
	logic [13:0] ev, pend;
	logic [2:0]  fl;
	logic [3:0]  seen;
	logic [7:0]  codes [14] = '{`RCFV_CODE_BROWN, `RCFV_CODE_PIN, `RCFV_CODE_SWBOR, `RCFV_CODE_WAKE,
		`RCFV_CODE_SECUR, `RCFV_CODE_SVSH, `RCFV_CODE_SWPOR, `RCFV_CODE_WDT, `RCFV_CODE_WATCHDOG_PASSWORD,
		`RCFV_CODE_MEMPW, `RCFV_CODE_UBE, `RCFV_CODE_FETCH, `RCFV_CODE_POWER_MGMT_PASSWORD, `RCFV_CODE_FLL};
	int          n_fail, n_compared, k, c;
	rcfv_top DUT (.ref_clk(ref_clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .brownout_event(ev[0]), .reset_pin_event(ev[1]), .software_brownout_request(ev[2]),
		.deep_wake_event(ev[3]), .security_violation(ev[4]), .high_side_supervisor_flag(ev[5]),
		.software_poweron_request(ev[6]), .watchdog_timeout_flag(ev[7]), .watchdog_password_bad(ev[8]),
		.memctl_password_bad(ev[9]), .uncorrectable_error_event(ev[10]), .correctable_error_event(fl[0]),
		.peripheral_fetch(ev[11]), .power_mgmt_password_bad(ev[12]), .fll_unlock(ev[13]),
		.access_violation_event(fl[1]), .crystal_one_fault(fl[2]), .mem_write_req(mem_write_req),
		.mem_write_info(mem_write_info), .mem_write_grant(mem_write_grant), .nmi_pulse(nmi_pulse),
		.pin_reset_req(pin_reset_req), .brownout_class_reset(brownout_class_reset),
		.power_up_clear_reset(power_up_clear_reset), .oscillator_fault_irq(oscillator_fault_irq));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// sticky record of the nmi and reset request pulses, cleared off the edge
	always @(posedge ref_clk) seen = seen | {nmi_pulse, pin_reset_req, brownout_class_reset, power_up_clear_reset};
	////////////////////////////////////////////////////////////////////////////////
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask : bus
	task pulse(input logic [13:0] e, input logic [2:0] f);
		ev <= e;
		fl <= f;
		@(negedge ref_clk) seen = '0;
		@(posedge ref_clk);
		ev <= '0;
		fl <= '0;
		repeat (3) @(posedge ref_clk);
	endtask : pulse
	// model: lowest pending index has top priority; each read pops one
	task drain;
		for (int i = 0; i < 15; i++) begin
			logic [7:0] ex;
			ex = `RCFV_CODE_NONE;
			for (int j = 13; j >= 0; j--) if (pend[j]) ex = codes[j];
			for (int j = 0; j < 14; j++) if (pend[j]) begin pend[j] = 1'b0; break; end
			bus(1'b0, 32'h0000_015E, '0);
			`CHK("vector", {24'h00_0000, ex}, r)
			if (ex == `RCFV_CODE_NONE) break;
		end
	endtask : drain
	task print_verdict;
		$display("counts compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, hwrite, mem_write_req, mem_write_info, htrans, haddr, hwdata, ev, fl, seen} = '0;
		void'($urandom(98627));
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		pend = 14'h0001;
		drain();
		$display("test reset_vector done");
		for (k = 0; k < 6; k++) begin
			m = (k == 0) ? 32'h0000_3FFF : $urandom();
			pulse(m[13:0], 3'b000);
			pend = m[13:0];
			`CHK("bor_class", |m[5:0], seen[1])
			`CHK("puc_class", |m[13:7], seen[0])
			`CHK("pin_req", m[1], seen[2])
			drain();
		end
		$display("test priority_walk done");
		@(negedge ref_clk) seen = '0;
		@(posedge ref_clk);
		bus(1'b1, 32'h0000_0160, 32'h0000_5A0F);
		repeat (3) @(posedge ref_clk);
		`CHK("bad_key_puc", 1'b1, seen[0])
		bus(1'b0, 32'h0000_0200, '0);
		`CHK("unmapped", 32'h0000_0000, r)
		for (c = 0; c < 8; c++) begin
			bus(1'b1, 32'h0000_0160, {16'h0000, `RCFV_PW_KEY, 5'h00, c[2:0]});
			pulse(14'h0002, 3'b000);
			pend = c[0] ? 14'h0000 : 14'h0002;
			`CHK("nmi", c[0], seen[3])
			`CHK("pin_req", !c[0], seen[2])
			drain();
			for (k = 0; k < 2; k++) begin
				mem_write_req  <= 1'b1;
				mem_write_info <= k[0];
				@(posedge ref_clk);
				mem_write_req <= 1'b0;
				@(posedge ref_clk);
				`CHK("grant", !c[k+1], mem_write_grant)
			end
		end
		$display("test control done");
		bus(1'b1, 32'h0000_0160, {16'h0000, `RCFV_PW_KEY, 8'h08});
		pulse(14'h0400, 3'b111);
		bus(1'b0, 32'h0000_0164, '0);
		`CHK("flags", 32'h0000_000F, r)
		`CHK("osc_irq", 1'b1, oscillator_fault_irq)
		bus(1'b1, 32'h0000_0164, 32'h0000_000F);
		bus(1'b0, 32'h0000_0164, '0);
		`CHK("flags_clr", 32'h0000_0000, r)
		pend = 14'h0400;
		drain();
		$display("test fault_flags done");
		print_verdict();
	end
endmodule : reset_cause_fault_vector_tb
